// ===== core/sfh_buffer.sv
// Two-entry flip-flop buffer with valid/ready on both sides.
// Assumes both sides run on clk and reset synchronously.
`timescale 1ns/100ps
module sfh_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic in_valid, // Word offered.
  output logic in_ready, // Room for a word.
  input wire logic [WIDTH-1:0] in_data, // Offered word.
  output logic out_valid, // Word available.
  input wire logic out_ready, // Consumer takes the word.
  output logic [WIDTH-1:0] out_data // Oldest word.
);
  localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DEPTH - 1);
  localparam logic [IDX_W:0] FILL_FULL = (IDX_W + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [IDX_W-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [IDX_W:0] fill_reg, fill_next;
  logic push, pop;

  assign in_ready = (fill_reg != FILL_FULL);
  assign out_valid = (fill_reg != '0);
  assign out_data = mem_reg[rp_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_next = mem_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    fill_next = fill_reg;
    if (push) begin
      mem_next[wp_reg] = in_data;
      wp_next = (wp_reg == IDX_LAST) ? '0 : IDX_W'(wp_reg + 1'b1);
    end
    if (pop) begin
      rp_next = (rp_reg == IDX_LAST) ? '0 : IDX_W'(rp_reg + 1'b1);
    end
    if (push && !pop) begin
      fill_next = (IDX_W + 1)'(fill_reg + 1'b1);
    end else if (pop && !push) begin
      fill_next = (IDX_W + 1)'(fill_reg - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      fill_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      fill_reg <= fill_next;
    end
    mem_reg <= mem_next;
  end

  AST_BUF_FILL_BOUND: assert property (@(posedge clk) disable iff (sys_rst)
    fill_reg <= FILL_FULL)
    else $error("buffer fill beyond depth");

endmodule // sfh_buffer

// ===== core/sfh_host_port.sv
// Host controller that drives a slave FIFO port in synchronous mode.
// Assumes the device samples on the interface clock made here, pins are
// asynchronous to clk, and the data pin is resolved outside.
// Behaviour
// - Read is valid only with chip select; select comes with or before.
// - Read data only appears under output enable; host keeps it on.
// - Write is valid only with chip select; select comes with or before.
// - Burst write holds strobe and chip select; one word per rise.
// - Commit may share the last write edge; that word is included.
// - FIFO select stays unchanged while the commit strobe is active.
// - Manual commit after an auto packet comes one clock later at least; not tracked here, a last-word commit can share that edge.
// - FIFO select is set at least 25 ns before it is used.
// - Chip select may be held active; port then counts as selected.
// - Asynchronous read strobe and output enable may be one signal.
`timescale 1ns/100ps
module sfh_host_port (
  input wire logic clk, // System clock, 125 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic cmd_valid, // Command offered.
  output logic cmd_ready, // Command taken when valid.
  input wire sfh_pkg::sfh_cmd_type cmd, // Operation, FIFO, word count.
  input wire logic [sfh_pkg::DATA_W-1:0] wr_data, // Word to write.
  input wire logic wr_valid, // Write word offered.
  output logic wr_ready, // Write word taken when valid.
  output logic [sfh_pkg::DATA_W-1:0] rd_data, // Word read.
  output logic rd_valid, // Read word available.
  input wire logic rd_ready, // Read word consumed.
  output logic interface_clock, // Clock driven to the device.
  output logic [1:0] fifo_select, // FIFO select lines.
  output logic port_chip_select, // Chip select pin.
  output logic port_output_enable, // Device data driver enable.
  output logic port_read_strobe, // Read strobe pin.
  output logic port_write_strobe, // Write strobe pin.
  output logic packet_commit_strobe, // Packet commit pin.
  input wire logic [sfh_pkg::DATA_W-1:0] fifo_data_in, // Data pin level.
  output logic [sfh_pkg::DATA_W-1:0] fifo_data_out, // Data we drive.
  output logic fifo_data_oe_n, // Low while we drive data.
  input wire logic dev_empty_flag, // Selected FIFO empty pin.
  input wire logic dev_full_flag // Selected FIFO full pin.
);
  import sfh_pkg::*;

  sfh_state_type state_reg, state_next;
  sfh_op_type op_reg, op_next;
  logic [3:0] phase_reg, phase_next, setup_reg, setup_next;
  logic [3:0] age_reg, age_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0] sel_reg, sel_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic cs_reg, cs_next, oe_reg, oe_next, rd_reg, rd_next;
  logic wr_reg, wr_next, pe_reg, pe_next, drive_reg, drive_next;
  logic cl_reg, cl_next, lclk_reg, lclk_next;
  logic [DATA_W+1:0] pin_s1_reg, pin_s2_reg;
  logic empty_s, full_s, buf_in_ready, push, period_end, go, fin;

  assign empty_s = (pin_s2_reg[DATA_W] == EMPTY_ACT);
  assign full_s = (pin_s2_reg[DATA_W+1] == FULL_ACT);
  assign period_end = (phase_reg == PH_LAST);
  // Capture just before the rise that advances the device pointer.
  // one entry per period
  assign push = rd_reg && (phase_reg == PH_SAMPLE);

  sfh_buffer #(
    .WIDTH(DATA_W),
    .DEPTH(BUF_DEPTH)
  ) u_rd_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .in_data(pin_s2_reg[DATA_W-1:0]),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    phase_next = 4'(phase_reg + 4'h1);
    setup_next = setup_reg;
    cnt_next = cnt_reg;
    sel_next = sel_reg;
    dout_next = dout_reg;
    cs_next = cs_reg;
    oe_next = oe_reg;
    rd_next = rd_reg;
    wr_next = wr_reg;
    pe_next = pe_reg;
    drive_next = drive_reg;
    cl_next = cl_reg;
    cmd_ready = 1'b0;
    wr_ready = 1'b0;
    go = 1'b0;
    fin = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        cmd_ready = 1'b1;
        if (cmd_valid) begin
          sel_next = cmd.sel;
          op_next = cmd.op;
          cnt_next = (cmd.op == OP_COMMIT) ? CNT_ONE : cmd.count;
          cl_next = cmd.commit_last;
          setup_next = SEL_SETUP_CYC;
          cs_next = 1'b1;
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (setup_reg != 4'h0) begin
          setup_next = 4'(setup_reg - 4'h1);
        end else if (period_end) begin
          case (op_reg)
            OP_NOP: fin = 1'b1;
            OP_READ: begin
              oe_next = 1'b1;
              state_next = ST_READ;
            end
            OP_WRITE: begin
              drive_next = 1'b1;
              state_next = ST_WRITE;
            end
            default: state_next = ST_COMMIT;
          endcase
        end
      end
      ST_READ: begin
        if (period_end) begin
          go = (cnt_reg != CNT_RST) && buf_in_ready && !empty_s;
          rd_next = go;
          fin = !go && (cnt_reg == CNT_RST);
        end
      end
      ST_WRITE: begin
        if (period_end) begin
          // one word per rise while available
          go = (cnt_reg != CNT_RST) && wr_valid && !full_s;
          wr_ready = go;
          wr_next = go;
          if (go) begin
            dout_next = wr_data;
          end
          // commit on the last write edge
          pe_next = go && cl_reg && (cnt_reg == CNT_ONE);
          fin = !go && (cnt_reg == CNT_RST);
        end
      end
      ST_COMMIT: begin
        if (period_end) begin
          go = (cnt_reg != CNT_RST);
          pe_next = go;
          fin = !go;
        end
      end
      default: fin = 1'b1;
    endcase
    if (go) begin
      cnt_next = CNT_W'(cnt_reg - CNT_ONE);
    end
    if (fin) begin
      state_next = ST_IDLE;
      cs_next = 1'b0;
      oe_next = 1'b0;
      drive_next = 1'b0;
    end
    lclk_next = (phase_next >= PH_RISE);
    age_next = !cs_reg ? 4'h0 : (age_reg == 4'hf) ? age_reg :
               4'(age_reg + 4'h1);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_NOP;
      phase_reg <= PH_RST;
      setup_reg <= 4'h0;
      age_reg <= 4'h0;
      cnt_reg <= CNT_RST;
      sel_reg <= SEL_RST;
      dout_reg <= DATA_RST;
      cs_reg <= 1'b0;
      oe_reg <= 1'b0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      pe_reg <= 1'b0;
      drive_reg <= 1'b0;
      cl_reg <= 1'b0;
      lclk_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      phase_reg <= phase_next;
      setup_reg <= setup_next;
      age_reg <= age_next;
      cnt_reg <= cnt_next;
      sel_reg <= sel_next;
      dout_reg <= dout_next;
      cs_reg <= cs_next;
      oe_reg <= oe_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      pe_reg <= pe_next;
      drive_reg <= drive_next;
      cl_reg <= cl_next;
      lclk_reg <= lclk_next;
    end
  end

  // Data and flags come from another domain; two stages before use.
  always_ff @(posedge clk) begin
    pin_s1_reg <= {dev_full_flag, dev_empty_flag, fifo_data_in};
    pin_s2_reg <= pin_s1_reg;
  end

  assign interface_clock = lclk_reg;
  assign fifo_select = sel_reg;
  assign port_chip_select = cs_reg ? CS_ACT : ~CS_ACT;
  assign port_output_enable = oe_reg ? OE_ACT : ~OE_ACT;
  assign port_read_strobe = rd_reg ? RD_ACT : ~RD_ACT;
  assign port_write_strobe = wr_reg ? WR_ACT : ~WR_ACT;
  assign packet_commit_strobe = pe_reg ? PE_ACT : ~PE_ACT;
  assign fifo_data_out = dout_reg;
  assign fifo_data_oe_n = ~drive_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_RD_NEEDS_CS: assert property (rd_reg |-> cs_reg)
    else $error("read strobe without chip select");
  AST_RD_CS_FIRST: assert property ($rose(rd_reg) |-> $past(cs_reg))
    else $error("chip select not ahead of read strobe");
  AST_RD_UNDER_OE: assert property (rd_reg |-> oe_reg && !drive_reg)
    else $error("read strobe without output enable");
  AST_WR_CS_FIRST: assert property ($rose(wr_reg) |->
    $past(cs_reg) && cs_reg && drive_reg)
    else $error("write strobe without chip select");
  AST_WR_HOLD_PERIOD: assert property (wr_reg && !period_end |=>
    wr_reg && cs_reg && $stable(dout_reg))
    else $error("write strobe or data moved inside a period");
  AST_PE_LAST_WORD: assert property (pe_reg && wr_reg |->
    cnt_reg == CNT_RST)
    else $error("commit shared with a word that is not the last");
  AST_PE_SEL_STABLE: assert property (pe_reg |=>
    $stable(sel_reg) || !pe_reg)
    else $error("select changed during commit");
  AST_PE_ALIGNED: assert property ($rose(pe_reg) |->
    phase_reg == PH_RST ##8 lclk_reg && pe_reg)
    else $error("commit not aligned to an interface clock period");
  AST_SEL_SETUP: assert property ($rose(rd_reg || wr_reg || pe_reg) |->
    age_reg >= SEL_SETUP_CYC)
    else $error("select setup shorter than required");
  AST_RD_CAPTURE: assert property ($rose(rd_reg) |-> ##7 push)
    else $error("read word not captured");

  CVR_RD_BURST: cover property (rd_reg && period_end ##1 rd_reg);
  CVR_WR_BURST: cover property (wr_reg && period_end ##1 wr_reg);
  CVR_PE_WITH_WR: cover property (pe_reg && wr_reg);
  CVR_PE_ALONE: cover property ($rose(pe_reg) && !wr_reg);

endmodule // sfh_host_port

// ===== core/sfh_pkg.sv
// Shared constants and types for the slave FIFO port host controller.
// Assumes a 125 MHz system clock; the interface clock is derived from it.
package sfh_pkg;

  localparam int DATA_W = 16;
  localparam int CNT_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam int CLK_PERIOD_NS = 8;
  // Interface clock period in system clock cycles (128 ns).
  localparam int LINK_DIV = 16;
  localparam logic [3:0] PH_RST = 4'h0;
  localparam logic [3:0] PH_SAMPLE = 4'(LINK_DIV / 2 - 1);
  localparam logic [3:0] PH_RISE = 4'(LINK_DIV / 2);
  localparam logic [3:0] PH_LAST = 4'(LINK_DIV - 1);
  // Least setup of the FIFO select ahead of its use.
  localparam int SEL_SETUP_NS = 25;
  localparam int SEL_SETUP_CYC_I =
    (SEL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SEL_SETUP_CYC = 4'(SEL_SETUP_CYC_I);
  // Active levels of the port pins, seen from the device.
  localparam logic CS_ACT = 1'b0;
  localparam logic OE_ACT = 1'b0;
  localparam logic RD_ACT = 1'b0;
  localparam logic WR_ACT = 1'b0;
  localparam logic PE_ACT = 1'b0;
  localparam logic EMPTY_ACT = 1'b0;
  localparam logic FULL_ACT = 1'b0;
  // Values after reset; CNT_ONE is the count step.
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  typedef enum logic [1:0] {
    OP_NOP = 2'h0,
    OP_READ = 2'h1,
    OP_WRITE = 2'h2,
    OP_COMMIT = 2'h3
  } sfh_op_type;

  typedef struct packed {
    sfh_op_type op;
    logic [1:0] sel;
    logic commit_last;
    logic [CNT_W-1:0] count;
  } sfh_cmd_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETUP = 5'h02,
    ST_READ = 5'h04,
    ST_WRITE = 5'h08,
    ST_COMMIT = 5'h10
  } sfh_state_type;

endpackage

// ===== verification/sfh_dev_model.sv
// Behavioural slave FIFO device: four FIFOs, flags and packet commit.
// Assumes it is clocked only by the interface clock that the host makes.
`timescale 1ns/100ps
module sfh_dev_model #(
  parameter int DEPTH = 6,
  parameter int AUTO_LEN = 6
) (
  input wire logic interface_clock, // Interface clock from the host.
  input wire logic [1:0] fifo_select, // FIFO select lines.
  input wire logic port_chip_select, // Chip select pin.
  input wire logic port_output_enable, // Output enable pin.
  input wire logic port_read_strobe, // Read strobe pin.
  input wire logic port_write_strobe, // Write strobe pin.
  input wire logic packet_commit_strobe, // Packet commit pin.
  input wire logic [sfh_pkg::DATA_W-1:0] host_data, // Host data.
  input wire logic host_oe_n, // Low while the host drives.
  output logic [sfh_pkg::DATA_W-1:0] pin_data, // Resolved data pin.
  output logic dev_empty_flag, // Empty flag pin.
  output logic dev_full_flag // Full flag pin.
);
  import sfh_pkg::*;
  logic [DATA_W-1:0] mem [4][DEPTH];
  logic [DATA_W-1:0] last_pin = '0;
  int rp [4] = '{default: 0};
  int wp [4] = '{default: 0};
  int cnt [4] = '{default: 0};
  int acc [4] = '{default: 0};
  int pkt_cnt [4] = '{default: 0};
  int last_len [4] = '{default: 0};
  int n_wr = 0;
  int proto_err = 0;
  realtime t_sel = 0;
  logic cs, oe, rd, wr, pe;
  assign cs = port_chip_select == CS_ACT;
  assign oe = port_output_enable == OE_ACT;
  assign rd = port_read_strobe == RD_ACT;
  assign wr = port_write_strobe == WR_ACT;
  assign pe = packet_commit_strobe == PE_ACT;
  // A released pin shows the inverse of its last level, so it is never kept.
  // Enable gates prefetch.
  assign pin_data = !host_oe_n ? host_data : (cs && oe) ?
    mem[fifo_select][rp[fifo_select]] : ~last_pin;
  assign dev_empty_flag = cnt[fifo_select] == 0 ? EMPTY_ACT : ~EMPTY_ACT;
  assign dev_full_flag = cnt[fifo_select] == DEPTH ? FULL_ACT : ~FULL_ACT;
  always @(fifo_select) t_sel = $realtime;
  always @(posedge interface_clock) begin
    int f;
    bit auto_now;
    f = fifo_select;
    auto_now = 0;
    last_pin <= pin_data;
    if ((rd || wr || pe) && $realtime - t_sel < SEL_SETUP_NS) proto_err++;
    if ((rd || wr) && !cs || rd && !oe || !host_oe_n && cs && oe) proto_err++;
    if (cs && wr) begin
      if (cnt[f] == DEPTH) proto_err++;
      else begin
        mem[f][wp[f]] = pin_data;
        wp[f] = (wp[f] + 1) % DEPTH;
        cnt[f]++;
        acc[f]++;
        n_wr++;
      end
      if (acc[f] == AUTO_LEN) begin
        pkt_cnt[f]++;
        last_len[f] = acc[f];
        acc[f] = 0;
        auto_now = 1;
      end
    end
    if (cs && pe) begin
      if (auto_now) proto_err++;
      pkt_cnt[f]++;
      last_len[f] = acc[f];
      acc[f] = 0;
    end
    if (cs && rd) begin
      if (cnt[f] == 0) proto_err++;
      else begin
        rp[f] = (rp[f] + 1) % DEPTH;
        cnt[f]--;
      end
    end
  end
  // Lets the bench remove one word from a FIFO from the far side of the device.
  task automatic drain(input int f);
    rp[f] = (rp[f] + 1) % DEPTH;
    cnt[f]--;
  endtask
endmodule // sfh_dev_model

// ===== verification/tb_top.sv
// Self-checking bench of the host port against the device model.
// Assumes sfh_pkg, the design files and sfh_dev_model are compiled first.
`timescale 1ns/100ps
`define DM i_sfh_dev_model
`define CHK(a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    failures++; \
    $display("ERROR at %0t got %0h exp %0h", $time, (a), (b)); \
  end \
end
module tb_top;
  import sfh_pkg::*;
  localparam int DEV_DEPTH = 6;
  localparam int AUTO_W = 6;
  logic clk = 0, sys_rst = 1, cmd_valid = 0, wr_valid = 0;
  logic rd_ready = 0, hold_rd = 0;
  sfh_cmd_type cmd = '0;
  logic [DATA_W-1:0] wr_data = '0, rd_data, fifo_data_in, fifo_data_out;
  logic [DATA_W-1:0] w, rw;
  logic cmd_ready, wr_ready, rd_valid, interface_clock, port_chip_select;
  logic port_output_enable, port_read_strobe, port_write_strobe;
  logic packet_commit_strobe, fifo_data_oe_n, dev_empty_flag, dev_full_flag;
  logic [1:0] fifo_select;
  logic [DATA_W-1:0] wq [$], rq [$], eq [4][$];
  int failures = 0, n_compared = 0, cycles = 0, tot = 2, k;
  sfh_host_port i_sfh_host_port (.clk, .sys_rst, .cmd_valid, .cmd_ready,
    .cmd, .wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid, .rd_ready,
    .interface_clock, .fifo_select, .port_chip_select, .port_output_enable,
    .port_read_strobe, .port_write_strobe, .packet_commit_strobe,
    .fifo_data_in, .fifo_data_out, .fifo_data_oe_n, .dev_empty_flag,
    .dev_full_flag);
  sfh_dev_model #(
    .DEPTH(DEV_DEPTH),
    .AUTO_LEN(AUTO_W)
  ) i_sfh_dev_model (.interface_clock, .fifo_select,
    .port_chip_select, .port_output_enable, .port_read_strobe,
    .port_write_strobe, .packet_commit_strobe, .host_data(fifo_data_out),
    .host_oe_n(fifo_data_oe_n), .pin_data(fifo_data_in), .dev_empty_flag,
    .dev_full_flag);
  always #4 clk = ~clk;
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  // Write feeder and read consumer run beside the command sequence.
  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) void'(wq.pop_front());
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      rw = rq.pop_front();
      `CHK(rd_data, rw)
    end
    #1;
    wr_valid = wq.size() != 0;
    wr_data = wq.size() != 0 ? wq[0] : DATA_W'($urandom);
    rd_ready = !hold_rd && ($urandom % 4 != 0);
  end
  // Packets the device commits by itself for n words from an empty count.
  function automatic int auto_pkts(input int n);
    return n / AUTO_W;
  endfunction
  task automatic put_words(input int f, input int n);
    repeat (n) begin
      w = DATA_W'($urandom);
      wq.push_back(w);
      eq[f].push_back(w);
    end
  endtask
  task automatic run_cmd(input sfh_op_type op, input logic [1:0] s,
                         input logic l, input int n);
    cmd = '{op, s, l, CNT_W'(n)};
    cmd_valid = 1;
    @(posedge clk);
    while (cmd_ready !== 1'b1) @(posedge clk);
    #1 cmd_valid = 0;
    repeat (3000) if (cmd_ready !== 1'b1 || wq.size() != 0) @(posedge clk);
    `CHK({cmd_ready, wq.size() == 0}, 2'b11)
    #1;
  endtask
  task automatic read_all(input int f);
    rq = eq[f];
    k = eq[f].size();
    eq[f] = {};
    run_cmd(OP_READ, 2'(f), 1'b0, k);
    repeat (400) if (rq.size() != 0) @(posedge clk);
    @(posedge clk);
    #1;
    `CHK(rq.size(), 0)
  endtask
  initial begin
    void'($urandom(32'h3d06_4581));
    repeat (20) @(posedge clk);
    #1 sys_rst = 0;
    for (int f = 0; f < 4; f++) begin
      k = 1 + $urandom % 3;
      tot += k;
      put_words(f, k);
      run_cmd(OP_WRITE, 2'(f), 1'b1, k);
      `CHK(`DM.pkt_cnt[f], 1)
      `CHK(`DM.last_len[f], k)
    end
    $display("test write_commit done");
    put_words(0, 2);
    run_cmd(OP_WRITE, 2'h0, 1'b0, 2);
    `CHK(`DM.pkt_cnt[0], 1)
    run_cmd(OP_COMMIT, 2'h0, 1'b0, 1);
    `CHK(`DM.last_len[0], 2)
    run_cmd(OP_NOP, 2'h1, 1'b0, 3);
    run_cmd(OP_WRITE, 2'h3, 1'b0, 0);
    `CHK(`DM.n_wr, tot)
    $display("test commit_op done");
    for (int f = 0; f < 4; f++) begin
      read_all(f);
      `CHK(`DM.cnt[f], 0)
    end
    $display("test read_back done");
    put_words(2, DEV_DEPTH + 1);
    fork
      run_cmd(OP_WRITE, 2'h2, 1'b0, DEV_DEPTH + 1);
      begin
        repeat (2000) if (`DM.cnt[2] != DEV_DEPTH) @(posedge clk);
        repeat (64) @(posedge clk);
        #2;
        `CHK(`DM.cnt[2], DEV_DEPTH)
        `CHK(wq.size(), 1)
        `CHK(`DM.pkt_cnt[2], 1 + auto_pkts(DEV_DEPTH))
        `DM.drain(2);
        `DM.drain(2);
        void'(eq[2].pop_front());
        void'(eq[2].pop_front());
      end
    join
    run_cmd(OP_COMMIT, 2'h2, 1'b0, 1);
    `CHK(`DM.last_len[2], 1)
    `CHK(`DM.pkt_cnt[2], 2 + auto_pkts(DEV_DEPTH))
    $display("test full_stall done");
    hold_rd = 1;
    fork
      read_all(2);
      begin
        repeat (150) @(posedge clk);
        #2;
        `CHK(`DM.cnt[2], DEV_DEPTH - 1 - BUF_DEPTH)
        hold_rd = 0;
      end
    join
    `CHK(`DM.proto_err, 0)
    $display("test buffer_stall done");
    summarize();
  end
endmodule // tb_top
